// *** rtl/ccl_map.vh ***
// Offsets, field positions, reset values and operation codes of the condition code block
`ifndef CCL_MAP_VH
`define CCL_MAP_VH

// ****************************************************************
// Register byte offsets on the register bus
// ****************************************************************
`define CCL_OFS_CCW      4'h0
`define CCL_OFS_STATUS   4'h4
`define CCL_OFS_AM_LO    4'h8
`define CCL_OFS_AM_HI    4'hc

// ****************************************************************
// Condition code word field positions
// ****************************************************************
`define CCL_B_HALT       15
`define CCL_B_MTOP       14
`define CCL_B_HALF       13
`define CCL_B_MEXT       12
`define CCL_B_MSB        11
`define CCL_B_ZERO       10
`define CCL_B_SERR       9
`define CCL_B_CARRY      8
`define CCL_F_IPM_HI     7
`define CCL_F_IPM_LO     5
`define CCL_B_SAT        4
`define CCL_F_PK_HI      3
`define CCL_F_PK_LO      0

// ****************************************************************
// Reset values
// ****************************************************************
`define CCL_CCW_RST      16'h00e0
`define CCL_AM_RST       36'h000000000

// ****************************************************************
// Execution unit operation codes
// ****************************************************************
`define CCL_OP_READ      3'h0
`define CCL_OP_ADD       3'h1
`define CCL_OP_SUB       3'h2
`define CCL_OP_AND       3'h3
`define CCL_OP_OR        3'h4
`define CCL_OP_XOR       3'h5
`define CCL_OP_BCDADD    3'h6
`define CCL_OP_ASL       3'h7

// ****************************************************************
// Bus responses
// ****************************************************************
`define CCL_RESP_OKAY    2'h0
`define CCL_RESP_SLVERR  2'h2

`endif

// *** rtl/ccl_core.v ***
// Condition code word, flag update logic, wide accumulator and register bus slave
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
`include "ccl_map.vh"

// Operation
// - Sixteen-bit word: halt, top ovf, half, ext ovf, msb, zero, serr, carry, mask, sat, bank.
// - Halt bit 0 stops core clocks on halt instruction; 1 makes it a no-op.
// - Set top overflow flag when a wide accumulator operation overflows into bit 35.
// - Set half carry when a carry leaves bit 3 of A or B in BCD add.
// - Set extension overflow flag when wide accumulator overflows into bit 31.
// - Set msb flag when read operand or result has its top bit one.
// - Set zero flag when read operand or result is all zeros.
// - Set signed error flag on two's complement overflow.
// - Set carry flag on arithmetic carry or borrow; shifts also use it.
// - Three-bit priority mask blocks interrupt requests below its value.
// - Saturating transfers return max positive or negative, by sign before overflow.
// - Bank field joined with program counter gives twenty-bit instruction address.
module ccl_core
(
  input  wire        aclk,
  input  wire        aresetn,
  // Register bus
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Execution unit: sixteen-bit operations
  input  wire        ex_op_valid,
  input  wire [2:0]  ex_op_code,
  input  wire [15:0] ex_opnd_a,
  input  wire [15:0] ex_opnd_b,
  input  wire        ex_opnd_is_b,
  output reg  [15:0] ex_result_q,
  // Execution unit: direct word write by instruction
  input  wire        ex_ccw_wr,
  input  wire [15:0] ex_ccw_wdata,
  // Wide accumulator
  input  wire        am_add_valid,
  input  wire [35:0] am_addend,
  input  wire        am_xfer_round,
  input  wire        am_xfer_trunc,
  output reg  [15:0] am_xfer_data_q,
  // Low-power halt
  input  wire        halt_instr_exec,
  input  wire        halt_wake,
  output reg         core_clk_stop_q,
  output reg         halt_nop_q,
  // Interrupt gate
  input  wire [2:0]  irq_level,
  output reg         irq_accept_q,
  // Address extension
  input  wire [15:0] pc_value,
  output reg  [19:0] inst_addr_q,
  // Word for the core
  output reg  [15:0] ccw_q
);

  // ****************************************************************
  // Decode helper
  // ****************************************************************

  // Address decode shared by the read and write paths
  function [1:0] ccl_dec;
    input [31:0] addr;
    begin
      ccl_dec = addr[3:2];
    end
  endfunction

  function ccl_hit;
    input [31:0] addr;
    begin
      ccl_hit = (addr[31:4] == 28'h0000000) && (addr[1:0] == 2'h0);
    end
  endfunction

  // ****************************************************************
  // Sixteen-bit flag computation
  // ****************************************************************

  reg  [16:0] sum17;
  reg  [4:0]  nib_lo;
  reg  [15:0] res;
  reg         c_new;
  reg         v_new;
  reg         c_upd;
  reg         v_upd;
  reg         h_upd;
  reg         h_new;

  // Result and flags for one operation; c_upd etc. say which flags it defines
  always @*
  begin
    sum17  = 17'h00000;
    nib_lo = 5'h00;
    res    = 16'h0000;
    c_new  = 1'b0;
    v_new  = 1'b0;
    c_upd  = 1'b0;
    v_upd  = 1'b0;
    h_upd  = 1'b0;
    h_new  = 1'b0;
    case (ex_op_code)
      `CCL_OP_READ:
      begin
        res   = ex_opnd_is_b ? ex_opnd_b : ex_opnd_a;
        v_upd = 1'b1;
      end
      `CCL_OP_ADD, `CCL_OP_BCDADD:
      begin
        sum17 = {1'b0, ex_opnd_a} + {1'b0, ex_opnd_b};
        res   = sum17[15:0];
        c_new = sum17[16];
        v_new = (ex_opnd_a[15] == ex_opnd_b[15]) && (res[15] != ex_opnd_a[15]);
        c_upd = 1'b1;
        v_upd = 1'b1;
        if (ex_op_code == `CCL_OP_BCDADD)
        begin
          // Carry out of bit 3 of the addressed accumulator byte
          nib_lo = ex_opnd_is_b ? ({1'b0, ex_opnd_a[3:0]} + {1'b0, ex_opnd_b[3:0]})
                                : ({1'b0, ex_opnd_a[11:8]} + {1'b0, ex_opnd_b[11:8]});
          h_new  = nib_lo[4];
          h_upd  = 1'b1;
        end
      end
      `CCL_OP_SUB:
      begin
        sum17 = {1'b0, ex_opnd_a} - {1'b0, ex_opnd_b};
        res   = sum17[15:0];
        c_new = sum17[16];
        v_new = (ex_opnd_a[15] != ex_opnd_b[15]) && (res[15] != ex_opnd_a[15]);
        c_upd = 1'b1;
        v_upd = 1'b1;
      end
      `CCL_OP_AND:
      begin
        res   = ex_opnd_a & ex_opnd_b;
        v_upd = 1'b1;
      end
      `CCL_OP_OR:
      begin
        res   = ex_opnd_a | ex_opnd_b;
        v_upd = 1'b1;
      end
      `CCL_OP_XOR:
      begin
        res   = ex_opnd_a ^ ex_opnd_b;
        v_upd = 1'b1;
      end
      `CCL_OP_ASL:
      begin
        res   = {ex_opnd_a[14:0], 1'b0};
        c_new = ex_opnd_a[15];
        v_new = ex_opnd_a[15] ^ ex_opnd_a[14];
        c_upd = 1'b1;
        v_upd = 1'b1;
      end
      default:
      begin
        res = 16'h0000;
      end
    endcase
  end

  // ****************************************************************
  // Wide accumulator arithmetic
  // ****************************************************************

  reg  [35:0] am_q;
  reg         am_sign_q;
  wire [36:0] am_sum;
  wire        am_top_ovf;
  wire        am_ext_ovf;

  // One extra bit keeps the true sign even when bit 35 is overrun
  assign am_sum     = {am_q[35], am_q} + {am_addend[35], am_addend};
  assign am_top_ovf = am_sum[36] != am_sum[35];
  assign am_ext_ovf = !((am_sum[35:31] == 5'h00) || (am_sum[35:31] == 5'h1f));

  // ****************************************************************
  // Register bus slave
  // ****************************************************************

  reg  [31:0] aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         aw_have_q;
  reg         w_have_q;
  wire        aw_take;
  wire        w_take;
  wire        wr_fire;
  wire        ccw_sw_wr;
  wire [15:0] ccw_sw_data;
  reg  [31:0] rd_word;

  assign aw_take   = s_axi_awvalid && s_axi_awready;
  assign w_take    = s_axi_wvalid && s_axi_wready;
  assign wr_fire   = aw_have_q && w_have_q && !s_axi_bvalid;
  assign ccw_sw_wr = wr_fire && ccl_hit(aw_addr_q) &&
                     (ccl_dec(aw_addr_q) == 2'h0);
  // Byte lanes above the low half carry no bits of the word
  assign ccw_sw_data = {w_strb_q[1] ? w_data_q[15:8] : ccw_q[15:8],
                        w_strb_q[0] ? w_data_q[7:0] : ccw_q[7:0]};

  // Write channel: address and data taken in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CCL_RESP_OKAY;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 32'h00000000;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_addr_q     <= s_axi_awaddr;
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_take)
      begin
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        // Read-only words take no write but answer OKAY; holes answer SLVERR
        s_axi_bresp  <= ccl_hit(aw_addr_q) ? `CCL_RESP_OKAY : `CCL_RESP_SLVERR;
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read word mux
  always @*
  begin
    rd_word = 32'h00000000;
    case (ccl_dec(s_axi_araddr))
      2'h0:    rd_word = {16'h0000, ccw_q};
      2'h1:    rd_word = {29'h00000000, am_sign_q, halt_nop_q, core_clk_stop_q};
      2'h2:    rd_word = am_q[31:0];
      2'h3:    rd_word = {28'h0000000, am_q[35:32]};
      default: rd_word = 32'h00000000;
    endcase
  end

  // Read channel: one read under way, answer one cycle after the address
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `CCL_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= ccl_hit(s_axi_araddr) ? rd_word : 32'h00000000;
      s_axi_rresp   <= ccl_hit(s_axi_araddr) ? `CCL_RESP_OKAY : `CCL_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************************************
  // Condition code word
  // ****************************************************************

  reg  [15:0] ccw_d;

  // Word writes first, then flags the operation defines override them,
  // so a hardware set is never lost to a clear in the same cycle
  always @*
  begin
    ccw_d = ccw_q;
    if (ex_ccw_wr)
      ccw_d = ex_ccw_wdata;
    else if (ccw_sw_wr)
      ccw_d = ccw_sw_data;
    if (ex_op_valid)
    begin
      ccw_d[`CCL_B_MSB]  = res[15];
      ccw_d[`CCL_B_ZERO] = (res == 16'h0000);
      if (v_upd)
        ccw_d[`CCL_B_SERR] = v_new;
      if (c_upd)
        ccw_d[`CCL_B_CARRY] = c_new;
      if (h_upd)
        ccw_d[`CCL_B_HALF] = h_new;
    end
    if (am_add_valid)
    begin
      // Top overflow stays set until written clear
      if (am_top_ovf)
        ccw_d[`CCL_B_MTOP] = 1'b1;
      ccw_d[`CCL_B_MEXT] = am_ext_ovf;
    end
  end

  // Word register; field layout fixed by the map bit positions
  always @(posedge aclk)
  begin
    if (!aresetn)
      ccw_q <= `CCL_CCW_RST;
    else
      ccw_q <= ccw_d;
  end

  // Operation result
  always @(posedge aclk)
  begin
    if (!aresetn)
      ex_result_q <= 16'h0000;
    else if (ex_op_valid)
      ex_result_q <= res;
  end

  // ****************************************************************
  // Wide accumulator and saturating transfers
  // ****************************************************************

  wire        sat_on;
  wire [16:0] rnd_sum;

  assign sat_on  = ccw_q[`CCL_B_SAT] && (ccw_q[`CCL_B_MEXT] || ccw_q[`CCL_B_MTOP]);
  assign rnd_sum = {1'b0, am_q[31:16]} + {16'h0000, am_q[15]};

  // Accumulator and the sign it would have without overflow
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      am_q      <= `CCL_AM_RST;
      am_sign_q <= 1'b0;
    end
    else if (am_add_valid)
    begin
      am_q      <= am_sum[35:0];
      am_sign_q <= am_sum[36];
    end
  end

  // Transfer of the upper word, clamped when saturation applies
  always @(posedge aclk)
  begin
    if (!aresetn)
      am_xfer_data_q <= 16'h0000;
    else if (am_xfer_round || am_xfer_trunc)
    begin
      if (sat_on)
        am_xfer_data_q <= am_sign_q ? 16'h8000 : 16'h7fff;
      else if (am_xfer_round)
        am_xfer_data_q <= rnd_sum[15:0];
      else
        am_xfer_data_q <= am_q[31:16];
    end
  end

  // ****************************************************************
  // Low-power halt, interrupt gate, address extension
  // ****************************************************************

  // Clock stop holds until a wake request; halt bit set turns it into a no-op
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_clk_stop_q <= 1'b0;
      halt_nop_q      <= 1'b0;
    end
    else
    begin
      halt_nop_q <= halt_instr_exec && ccw_q[`CCL_B_HALT];
      if (halt_instr_exec && !ccw_q[`CCL_B_HALT])
        core_clk_stop_q <= 1'b1;
      else if (halt_wake)
        core_clk_stop_q <= 1'b0;
    end
  end

  // Level 0 means no request; lower levels than the mask are blocked
  always @(posedge aclk)
  begin
    if (!aresetn)
      irq_accept_q <= 1'b0;
    else
      irq_accept_q <= (irq_level != 3'h0) &&
                      (irq_level >= ccw_q[`CCL_F_IPM_HI:`CCL_F_IPM_LO]);
  end

  // Twenty-bit fetch address, one cycle behind the inputs
  always @(posedge aclk)
  begin
    if (!aresetn)
      inst_addr_q <= 20'h00000;
    else
      inst_addr_q <= {ccw_q[`CCL_F_PK_HI:`CCL_F_PK_LO], pc_value};
  end

endmodule

// *** dv/ccl_chk.sv ***
// Concurrent checks on the condition code block ports
`timescale 1ns/10ps
`include "ccl_map.vh"
module ccl_chk
(
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awready,
  input wire        ex_op_valid,
  input wire [2:0]  ex_op_code,
  input wire [15:0] ex_opnd_a,
  input wire [15:0] ex_opnd_b,
  input wire        ex_opnd_is_b,
  input wire        ex_ccw_wr,
  input wire [15:0] ex_result_q,
  input wire        halt_instr_exec,
  input wire        core_clk_stop_q,
  input wire        halt_nop_q,
  input wire [2:0]  irq_level,
  input wire        irq_accept_q,
  input wire [15:0] pc_value,
  input wire [19:0] inst_addr_q,
  input wire [15:0] ccw_q
);
  // ********
  // Flag, halt, mask and address checks
  // ********
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Read picks the selected operand
  property p_read;
    ex_op_valid && ex_op_code == `CCL_OP_READ |=> ccw_q[11] == ex_result_q[15] &&
      ex_result_q == ($past(ex_opnd_is_b) ? $past(ex_opnd_b) : $past(ex_opnd_a));
  endproperty
  a_read: assert property (p_read) else $error("read operand or msb flag wrong");
  property p_logic;
    ex_op_valid && ex_op_code inside {`CCL_OP_AND, `CCL_OP_OR, `CCL_OP_XOR} |=>
      ccw_q[10] == (ex_result_q == 16'h0000) && !ccw_q[9];
  endproperty
  a_logic: assert property (p_logic) else $error("logic zero flag wrong");
  property p_add;
    ex_op_valid && ex_op_code == `CCL_OP_ADD |=> ccw_q[9] == ($past(ex_opnd_a[15]) ==
      $past(ex_opnd_b[15]) && ex_result_q[15] != $past(ex_opnd_a[15]));
  endproperty
  a_add: assert property (p_add) else $error("add overflow flag wrong");
  property p_asl;
    ex_op_valid && ex_op_code == `CCL_OP_ASL |=> ccw_q[8] == $past(ex_opnd_a[15]) &&
      ex_result_q == {$past(ex_opnd_a[14:0]), 1'h0};
  endproperty
  a_asl: assert property (p_asl) else $error("shift carry wrong");
  // Halt stops clocks or acts as a no-op
  property p_stop;
    halt_instr_exec && !ccw_q[15] |-> ##[1:2] core_clk_stop_q;
  endproperty
  a_stop: assert property (p_stop) else $error("halt did not stop");
  property p_nop;
    halt_instr_exec && ccw_q[15] && !core_clk_stop_q |-> ##[1:2] halt_nop_q && !core_clk_stop_q;
  endproperty
  a_nop: assert property (p_nop) else $error("halt no-op wrong");
  property p_irq;
    1'h1 |=> irq_accept_q == ($past(irq_level) != 3'h0 && $past(irq_level) >= $past(ccw_q[7:5]));
  endproperty
  a_irq: assert property (p_irq) else $error("priority mask wrong");
  property p_addr;
    1'h1 |=> inst_addr_q == {$past(ccw_q[3:0]), $past(pc_value)};
  endproperty
  a_addr: assert property (p_addr) else $error("bank address wrong");
  // Sticky top overflow survives all but a word write
  property p_mtop;
    ccw_q[14] && !ex_ccw_wr && s_axi_awready |=> ccw_q[14];
  endproperty
  a_mtop: assert property (p_mtop) else $error("top overflow lost");
endmodule

bind ccl_core ccl_chk u_ccl_chk (.aclk, .aresetn, .s_axi_awready, .ex_op_valid, .ex_op_code,
  .ex_opnd_a, .ex_opnd_b, .ex_opnd_is_b, .ex_ccw_wr, .ex_result_q, .halt_instr_exec,
  .core_clk_stop_q, .halt_nop_q, .irq_level, .irq_accept_q, .pc_value, .inst_addr_q, .ccw_q);

// *** dv/ccl_exu_model.sv ***
// Execution unit model driving operation, word-write and accumulator strobes
`timescale 1ns/10ps
module ccl_exu_model
(
  input  wire        aclk,
  output wire        ex_op_valid,
  output wire        ex_ccw_wr,
  output wire        am_add_valid,
  output wire        am_xfer_round,
  output wire        am_xfer_trunc,
  output wire        halt_instr_exec,
  output wire        halt_wake,
  output reg  [2:0]  ex_op_code = 3'h0,
  output reg  [15:0] ex_opnd_a = 16'h0,
  output reg  [15:0] ex_opnd_b = 16'h0,
  output reg         ex_opnd_is_b = 1'h0,
  output reg  [15:0] ex_ccw_wdata = 16'h0,
  output reg  [35:0] am_addend = 36'h0
);
  reg [6:0] stb_q = 7'h00;

  // One strobe per kind of step
  assign {ex_op_valid, ex_ccw_wr, am_add_valid, am_xfer_round, am_xfer_trunc,
          halt_instr_exec, halt_wake} = stb_q;

  // One-cycle step; data inverted afterwards so stale values never look valid
  task go(input [6:0] s, input [2:0] c, input [35:0] d, input [15:0] b, input i);
  begin
    @(posedge aclk);
    stb_q <= s;
    ex_op_code <= c;
    ex_opnd_a <= d[15:0];
    ex_opnd_b <= b;
    ex_opnd_is_b <= i;
    ex_ccw_wdata <= d[15:0];
    am_addend <= d;
    @(posedge aclk);
    stb_q <= 7'h00;
    ex_opnd_a <= ~d[15:0];
    ex_opnd_b <= ~b;
    ex_ccw_wdata <= ~d[15:0];
    am_addend <= ~d;
  end
  endtask
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the condition code block
`timescale 1ns/10ps
`include "ccl_map.vh"
module tb;
  localparam [6:0] S_OP = 7'h40, S_CW = 7'h20, S_AM = 7'h10, S_RN = 7'h08, S_TR = 7'h04;
  localparam [6:0] S_HL = 7'h02, S_WK = 7'h01;
  reg         aclk = 1'h0, aresetn = 1'h0;
  reg  [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  reg  [3:0]  s_axi_wstrb = 4'h0;
  reg         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  reg         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        ex_op_valid, ex_opnd_is_b, ex_ccw_wr, am_add_valid, am_xfer_round;
  wire        am_xfer_trunc, halt_instr_exec, halt_wake, core_clk_stop_q, halt_nop_q;
  wire        irq_accept_q;
  wire [2:0]  ex_op_code;
  wire [15:0] ex_opnd_a, ex_opnd_b, ex_ccw_wdata, ex_result_q, am_xfer_data_q, ccw_q;
  wire [35:0] am_addend;
  wire [19:0] inst_addr_q;
  reg  [2:0]  irq_level = 3'h0;
  reg  [15:0] pc_value = 16'h0, m, e;
  reg  [31:0] seed = 32'h1218, rd;
  reg  [1:0]  rp;
  reg  [35:0] am_m;
  reg  [36:0] s37;
  reg         neg_m;
  integer     mismatches = 0, tests_run = 0, i;

  // 25 MHz clock
  always #20 aclk = ~aclk;

  ccl_core u_ccl_core (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ex_op_valid, .ex_op_code, .ex_opnd_a, .ex_opnd_b,
    .ex_opnd_is_b, .ex_result_q, .ex_ccw_wr, .ex_ccw_wdata, .am_add_valid, .am_addend,
    .am_xfer_round, .am_xfer_trunc, .am_xfer_data_q, .halt_instr_exec, .halt_wake,
    .core_clk_stop_q, .halt_nop_q, .irq_level, .irq_accept_q, .pc_value, .inst_addr_q, .ccw_q);
  ccl_exu_model u_ccl_exu_model (.aclk, .ex_op_valid, .ex_ccw_wr, .am_add_valid,
    .am_xfer_round, .am_xfer_trunc, .halt_instr_exec, .halt_wake, .ex_op_code, .ex_opnd_a,
    .ex_opnd_b, .ex_opnd_is_b, .ex_ccw_wdata, .am_addend);

  // ********
  // Checking, bus and model tasks
  // ********
  task chk(input string n, input [35:0] sv, input [35:0] ev);
  begin
    tests_run = tests_run + 1;
    if (sv !== ev)
    begin
      mismatches = mismatches + 1;
      $display("MISMATCH %s expected %h seen %h", n, ev, sv);
    end
  end
  endtask

  task complete_run;
  begin
    if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask

  function [31:0] xs(input [31:0] x);
  begin
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  end
  endfunction

  // Address and data offered together, response awaited with bready up
  task axi_wr(input [31:0] ad, input [31:0] dt);
  begin
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {ad, dt, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid);
    rp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  end
  endtask

  task axi_rd(input [31:0] ad);
  begin
    @(posedge aclk);
    s_axi_araddr <= ad;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid);
    {rd, rp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'h0;
  end
  endtask

  task step(input [6:0] s, input [2:0] c, input [35:0] d, input [15:0] b, input bi);
  begin
    u_ccl_exu_model.go(s, c, d, b, bi);
    #1;
  end
  endtask

  // Model of the sixteen-bit operations
  task op(input [2:0] c, input [15:0] a, input [15:0] b, input bi);
    reg [16:0] s;
  begin
    case (c)
      `CCL_OP_ADD: s = {1'h0, a} + {1'h0, b};
      `CCL_OP_SUB: s = {1'h0, a} - {1'h0, b};
      `CCL_OP_AND: s = {1'h0, a & b};
      `CCL_OP_OR:  s = {1'h0, a | b};
      `CCL_OP_XOR: s = {1'h0, a ^ b};
      `CCL_OP_ASL: s = {a, 1'h0};
      default:     s = {1'h0, bi ? b : a};
    endcase
    m[9] = c == `CCL_OP_ADD ? a[15] == b[15] && s[15] != a[15] :
           c == `CCL_OP_SUB ? a[15] != b[15] && s[15] != a[15] : c == `CCL_OP_ASL && a[15] ^ a[14];
    {m[11], m[10]} = {s[15], s[15:0] == 16'h0000};
    if (c == `CCL_OP_ADD || c == `CCL_OP_SUB || c == `CCL_OP_ASL)
      m[8] = s[16];
    step(S_OP, c, {20'h0, a}, b, bi);
    chk("result", ex_result_q, s[15:0]);
    chk("word", ccw_q, m);
    chk("inst addr", inst_addr_q, {m[3:0], pc_value});
  end
  endtask

  task word_wr(input [15:0] w);
  begin
    m = w;
    step(S_CW, 3'h0, {20'h0, w}, 16'h0, 1'h0);
    chk("word", ccw_q, m);
  end
  endtask

  // Wide accumulator add; top overflow is sticky
  task am_add(input [35:0] d);
  begin
    s37 = {am_m[35], am_m} + {d[35], d};
    {neg_m, am_m} = {s37[36], s37[35:0]};
    if (s37[36] != s37[35])
      m[14] = 1'h1;
    m[12] = am_m[35:31] != 5'h00 && am_m[35:31] != 5'h1f;
    step(S_AM, 3'h0, d, 16'h0, 1'h0);
    chk("word", ccw_q, m);
  end
  endtask

  task xfer(input rn);
  begin
    e = rn ? am_m[31:16] + am_m[15] : am_m[31:16];
    if (m[4] && (m[12] || m[14]))
      e = neg_m ? 16'h8000 : 16'h7fff;
    step(rn ? S_RN : S_TR, 3'h0, 36'h0, 16'h0, 1'h0);
    chk("xfer", am_xfer_data_q, e);
  end
  endtask

  // Main sequence
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    {m, am_m, neg_m} = {`CCL_CCW_RST, `CCL_AM_RST, 1'h0};
    axi_rd(32'h0);
    chk("reset word", rd, {16'h0, m});
    axi_rd(32'h12);
    chk("unmapped", {rd, rp}, {32'h0, `CCL_RESP_SLVERR});
    axi_wr(32'h4, 32'hffff);
    chk("ro write", {ccw_q, rp}, {m, `CCL_RESP_OKAY});
    axi_wr(32'h0, 32'h5a5a_0a45);
    axi_rd(32'h0);
    chk("bus word", rd, 32'h0a45);
    word_wr(16'h006a);
    for (i = 0; i < 8; i = i + 1)
      if (i != 6)
        op(i, 16'h8000, 16'h8000, i[0]);
    op(`CCL_OP_ADD, 16'h7fff, 16'h0001, 1'h0);
    op(`CCL_OP_SUB, 16'h0000, 16'h0001, 1'h0);
    for (i = 0; i < 60; i = i + 1)
    begin
      @(posedge aclk);
      seed = xs(seed);
      {irq_level, pc_value} <= {seed[6:4], seed[31:16]};
      e = seed[15:0];
      seed = xs(seed);
      op(seed[2:0] == 3'h6 ? 3'h0 : seed[2:0], e, seed[31:16], seed[3]);
      chk("irq accept", irq_accept_q, irq_level != 3'h0 && irq_level >= m[7:5]);
    end
    word_wr(16'h0000);
    step(S_OP, `CCL_OP_BCDADD, 36'h9, 16'h0008, 1'h1);
    chk("half", ccw_q[13], 1'h1);
    step(S_OP, `CCL_OP_BCDADD, 36'h0901, 16'h0801, 1'h1);
    chk("half", ccw_q[13], 1'h0);
    step(S_OP, `CCL_OP_BCDADD, 36'h0901, 16'h0801, 1'h0);
    chk("half", ccw_q[13], 1'h1);
    word_wr(16'h0010);
    am_add(36'h080000000);
    xfer(1'h0);
    am_add(36'h7ffffffff);
    xfer(1'h1);
    axi_rd(`CCL_OFS_AM_LO);
    chk("am low", rd, am_m[31:0]);
    axi_rd(`CCL_OFS_AM_HI);
    chk("am high", rd, am_m[35:32]);
    am_add(36'h800000000);
    xfer(1'h0);
    am_add(36'h000000001);
    word_wr(16'h0000);
    xfer(1'h0);
    xfer(1'h1);
    step(S_HL, 3'h0, 36'h0, 16'h0, 1'h0);
    @(posedge aclk);
    chk("clock stop", core_clk_stop_q, 1'h1);
    axi_rd(`CCL_OFS_STATUS);
    chk("status", rd, {neg_m, 2'h1});
    step(S_WK, 3'h0, 36'h0, 16'h0, 1'h0);
    @(posedge aclk);
    word_wr(16'h8000);
    step(S_HL, 3'h0, 36'h0, 16'h0, 1'h0);
    chk("nop pulse", halt_nop_q, 1'h1);
    @(posedge aclk);
    chk("no stop", core_clk_stop_q, 1'h0);
    complete_run;
  end

  // Hang guard, far beyond the expected run of about three hundred cycles
  initial
  begin
    #400000;
    mismatches = mismatches + 1;
    complete_run;
  end
endmodule
